// [hdl/dpf_pkg.sv]
// Constants for the dual-clock FIFO port-control block
package dpf_pkg;
  localparam int DATA_W = 36;
  localparam int ADDR_W = 19;
  localparam int PTR_W  = ADDR_W + 1;
  localparam int OFF_W  = ADDR_W;
  localparam logic [PTR_W-1:0] DEPTH = 20'h80000;
  localparam logic [OFF_W-1:0] EMPTY_OFF_RST = 19'h0007F;
  localparam logic [OFF_W-1:0] FULL_OFF_RST  = 19'h0007F;
  localparam int LVL_W = 17;
  localparam int CLK_N = 3;
  localparam int SCLK_IDX = 0;
  localparam int RCLK_IDX = 1;
  localparam int WCLK_IDX = 2;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_COUNT     = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h10;
  localparam logic [7:0] REG_EMPTY_OFF = 8'h14;
  localparam logic [7:0] REG_FULL_OFF  = 8'h18;
  // Control bits
  localparam int CTRL_W       = 2;
  localparam int CTRL_MRST    = 0;
  localparam int CTRL_PRST    = 1;
  // Interrupt bits
  localparam int IRQ_W        = 4;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_UNDERRUN = 1;
  localparam int IRQ_RETX     = 2;
  localparam int IRQ_MARK     = 3;
  // Status bits
  localparam int ST_W         = 10;
  localparam int ST_EMPTY     = 0;
  localparam int ST_FULL      = 1;
  localparam int ST_SYNC_RD   = 2;
  localparam int ST_SYNC_WR   = 3;
  localparam int ST_FALL      = 4;
  localparam int ST_FLAGMODE  = 5;
  localparam int ST_SERIAL    = 6;
  localparam int ST_MARKED    = 7;
  localparam int ST_WLEVEL    = 8;
  localparam int ST_RLEVEL    = 9;
  typedef enum logic {OFF_SEL_EMPTY, OFF_SEL_FULL} dpf_off_e;
endpackage

// [hdl/dpf_sync.sv]
// Two-flop synchroniser with rising-edge detect for pin inputs
module dpf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] in_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Only s2 and s3 feed logic; s1 may be metastable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce_i) begin
      s1_q <= in_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level_o = s2_q;
  assign rise_o  = s2_q & ~s3_q;
endmodule

// [hdl/dpf_port_ctrl.sv]
// Port control of a dual-clock FIFO: strobes, retransmit, offsets, registers
// Operation
// - Asynchronous read port fetches one word per read strobe rising edge.
// - Synchronous read port acts on read clock edge only with read enable; fall-through also fetches while no word is held.
// - Read select sampled on read clock gates synchronous reads and output drive.
// - During resets read select ignored; low output enable drives outputs.
// - Retransmit on read edge rewinds read pointer, forces empty/not ready.
// - Retransmit keeps write pointer, modes and offsets.
// - Recorded mark replaces zero as retransmit target.
// - Serial clock edge with serial enable shifts serial bit into offsets.
// - Synchronous write port writes on write clock edge only with enable.
// - Asynchronous write port stores one word per write strobe rising edge.
// - In high-speed level mode, deasserted write select disables inputs.
// - Read timing select latched in master reset; async forces standard mode.
// - Write timing select latched during master reset.
// - Mark records current read pointer for later retransmits.
// - Offset access redirects port reads and writes to offset registers.
//
// Register access over Wishbone and the address map were left to the implementer.
module dpf_port_ctrl
  import dpf_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   irq_o,
  input  wire logic              wr_clk_i,
  input  wire logic              wr_en_n_i,
  input  wire logic              write_select_n_i,
  input  wire logic              write_port_level_select_i,
  input  wire logic              write_port_timing_select_i,
  input  wire logic [DATA_W-1:0] din_i,
  input  wire logic              rd_clk_i,
  input  wire logic              rd_en_n_i,
  input  wire logic              read_select_n_i,
  input  wire logic              read_port_level_select_i,
  input  wire logic              read_port_timing_select_i,
  input  wire logic              out_en_n_i,
  input  wire logic              retransmit_n_i,
  input  wire logic              mark_i,
  input  wire logic              ser_clk_i,
  input  wire logic              serial_load_enable_n_i,
  input  wire logic              first_word_fall_through_i,
  input  wire logic              offset_access_n_i,
  input  wire logic              flag_timing_mode_select_i,
  input  wire logic              master_reset_n_i,
  input  wire logic              partial_reset_n_i,
  output logic      [DATA_W-1:0] dout_o,
  output logic                   dout_oe_o,
  output logic                   empty_flag_n_o,
  output logic                   full_flag_n_o
);
  logic [LVL_W-1:0]  lvl_s;
  logic [CLK_N-1:0]  clk_rise;
  logic [DATA_W-1:0] din_s;
  logic wen_n, wsel_n, write_port_level_select, wtim, ren_n, rsel_n, read_port_level_select, rtim, oe_n;
  logic retx_n, mark, sload_n, si, ld_n, flag_timing_mode_select, mrst_n, prst_n;
  logic wr_edge, rd_edge, sc_edge, in_mrst, in_rst, empty, full, wr_gate;
  logic wr_req, wr_off, wr_mem, rd_req, rd_off, rd_mem, retx, underrun;
  logic [PTR_W-1:0]  wptr_q, rptr_q, mark_ptr_q, count;
  logic [OFF_W-1:0]  empty_off_q, full_off_q;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] dout_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0]  irq_stat_q, irq_mask_q, irq_ev, irq_clr;
  logic [ST_W-1:0]   status;
  logic [31:0]       rd_mux, wb_dat_q;
  logic cfg_sync_rd_q, cfg_sync_wr_q, cfg_fall_q, cfg_flagmode_q, cfg_serial_q;
  logic mark_valid_q, q_valid_q, retx_force_q, rsel_n_q, dout_oe_q, ack_q, wb_hit;
  dpf_off_e wsel_st_q, rsel_st_q;

  // Every pin passes two flops; data and strobes share the same delay
  dpf_sync #(.W(LVL_W)) u_sync_lvl (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .in_i    ({wr_en_n_i, write_select_n_i, write_port_level_select_i,
               write_port_timing_select_i, rd_en_n_i, read_select_n_i,
               read_port_level_select_i, read_port_timing_select_i, out_en_n_i,
               retransmit_n_i, mark_i, serial_load_enable_n_i,
               first_word_fall_through_i, offset_access_n_i,
               flag_timing_mode_select_i, master_reset_n_i, partial_reset_n_i}),
    .level_o (lvl_s),
    .rise_o  ()
  );
  dpf_sync #(.W(CLK_N)) u_sync_clk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .in_i    ({wr_clk_i, rd_clk_i, ser_clk_i}),
    .level_o (),
    .rise_o  (clk_rise)
  );
  dpf_sync #(.W(DATA_W)) u_sync_din (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .in_i    (din_i),
    .level_o (din_s),
    .rise_o  ()
  );

  assign {wen_n, wsel_n, write_port_level_select, wtim, ren_n, rsel_n, read_port_level_select, rtim, oe_n,
          retx_n, mark, sload_n, si, ld_n, flag_timing_mode_select, mrst_n, prst_n} = lvl_s;
  assign wr_edge = clk_rise[WCLK_IDX];
  assign rd_edge = clk_rise[RCLK_IDX];
  assign sc_edge = clk_rise[SCLK_IDX];
  assign in_mrst = ~mrst_n | ctrl_q[CTRL_MRST];
  assign in_rst  = in_mrst | ~prst_n | ctrl_q[CTRL_PRST];
  assign count   = wptr_q - rptr_q;
  assign empty   = (count == '0);
  assign full    = (count == DEPTH);

  // Write port
  assign wr_gate = write_port_level_select & wsel_n;
  assign wr_req  = wr_edge & ~in_rst & ~wr_gate & (cfg_sync_wr_q ? ~wen_n : 1'b1);
  assign wr_off  = wr_req & ~ld_n;
  assign wr_mem  = wr_req & ld_n & ~full;

  // Read port; retransmit beats a read on the same edge
  assign retx     = rd_edge & ~in_rst & ~retx_n;
  assign rd_req   = rd_edge & ~in_rst & (cfg_sync_rd_q ? (~ren_n & ~rsel_n) : 1'b1);
  assign rd_off   = rd_req & ~ld_n & ~retx;
  assign rd_mem   = ~retx & ld_n & ~empty &
                    (cfg_fall_q ? (rd_edge & ~in_rst & (~q_valid_q | rd_req)) : rd_req);
  assign underrun = rd_req & ld_n & empty & ~retx & ~cfg_fall_q;

  // Configuration caught while master reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_sync_rd_q  <= 1'b1;
      cfg_sync_wr_q  <= 1'b1;
      cfg_fall_q     <= 1'b0;
      cfg_flagmode_q <= 1'b0;
      cfg_serial_q   <= 1'b0;
    end else if (ce_i && in_mrst) begin
      cfg_sync_rd_q  <= rtim;
      cfg_sync_wr_q  <= wtim;
      cfg_fall_q     <= si & rtim;
      cfg_flagmode_q <= flag_timing_mode_select;
      cfg_serial_q   <= ~ld_n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || in_rst) begin
      wptr_q <= '0;
    end else if (ce_i && wr_mem) begin
      wptr_q <= wptr_q + 20'h00001;
    end
  end

  // No reset on the array: it is far too large and pointers make it invisible
  always_ff @(posedge clk_i) begin
    if (ce_i && wr_mem) begin
      mem[wptr_q[ADDR_W-1:0]] <= din_s;
    end
  end

  // Offsets survive partial reset and retransmit
  always_ff @(posedge clk_i) begin
    if (rst_i || in_mrst) begin
      empty_off_q <= EMPTY_OFF_RST;
      full_off_q  <= FULL_OFF_RST;
    end else if (ce_i) begin
      if (sc_edge && !sload_n) begin
        {empty_off_q, full_off_q} <= {empty_off_q[OFF_W-2:0], full_off_q, si};
      end else if (wr_off) begin
        case (wsel_st_q)
          OFF_SEL_EMPTY: empty_off_q <= din_s[OFF_W-1:0];
          OFF_SEL_FULL:  full_off_q  <= din_s[OFF_W-1:0];
          default:       empty_off_q <= empty_off_q;
        endcase
      end
    end
  end

  // Parallel offset access alternates empty then full offset
  always_ff @(posedge clk_i) begin
    if (rst_i || in_mrst) begin
      wsel_st_q <= OFF_SEL_EMPTY;
      rsel_st_q <= OFF_SEL_EMPTY;
    end else if (ce_i) begin
      if (wr_off) begin
        wsel_st_q <= (wsel_st_q == OFF_SEL_EMPTY) ? OFF_SEL_FULL : OFF_SEL_EMPTY;
      end
      if (rd_off) begin
        rsel_st_q <= (rsel_st_q == OFF_SEL_EMPTY) ? OFF_SEL_FULL : OFF_SEL_EMPTY;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || in_rst) begin
      rptr_q <= '0;
    end else if (ce_i) begin
      if (retx) begin
        rptr_q <= mark_valid_q ? mark_ptr_q : '0;
      end else if (rd_mem) begin
        rptr_q <= rptr_q + 20'h00001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || in_rst) begin
      mark_valid_q <= 1'b0;
      mark_ptr_q   <= '0;
    end else if (ce_i && rd_edge && mark) begin
      mark_valid_q <= 1'b1;
      mark_ptr_q   <= rptr_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || in_rst) begin
      dout_q <= '0;
    end else if (ce_i) begin
      if (rd_mem) begin
        dout_q <= mem[rptr_q[ADDR_W-1:0]];
      end else if (rd_off) begin
        dout_q <= {{(DATA_W-OFF_W){1'b0}},
                   (rsel_st_q == OFF_SEL_EMPTY) ? empty_off_q : full_off_q};
      end
    end
  end

  // Flag state: fall-through valid word and the post-retransmit empty hold
  always_ff @(posedge clk_i) begin
    if (rst_i || in_rst) begin
      q_valid_q    <= 1'b0;
      retx_force_q <= 1'b0;
    end else if (ce_i) begin
      if (retx) begin
        q_valid_q <= 1'b0;
      end else if (rd_mem) begin
        q_valid_q <= 1'b1;
      end else if (rd_req && ld_n) begin
        q_valid_q <= 1'b0;
      end
      if (retx) begin
        retx_force_q <= 1'b1;
      end else if (rd_edge) begin
        retx_force_q <= 1'b0;
      end
    end
  end

  assign empty_flag_n_o = cfg_fall_q ? ~q_valid_q : ~(empty | retx_force_q);
  assign full_flag_n_o  = ~full;

  // Output drive registered so it follows the read clock sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsel_n_q  <= 1'b1;
      dout_oe_q <= 1'b0;
    end else if (ce_i) begin
      if (rd_edge) begin
        rsel_n_q <= rsel_n;
      end
      dout_oe_q <= in_rst ? ~oe_n : (~oe_n & ~rsel_n_q);
    end
  end

  assign dout_o    = dout_q;
  assign dout_oe_o = dout_oe_q;

  // Register bus, one wait state
  assign wb_hit  = wb_cyc_i & wb_stb_i & ~ack_q;
  assign irq_ev  = {rd_edge & mark & ~in_rst, retx, underrun, wr_req & ld_n & full};
  assign irq_clr = (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_IRQ_STAT) ?
                   wb_dat_i[IRQ_W-1:0] : '0;
  assign status  = {read_port_level_select, write_port_level_select, mark_valid_q, cfg_serial_q, cfg_flagmode_q, cfg_fall_q,
                    cfg_sync_wr_q, cfg_sync_rd_q, full, empty};

  always_comb begin
    case (wb_adr_i)
      REG_CTRL:      rd_mux = {{(32-CTRL_W){1'b0}}, ctrl_q};
      REG_STATUS:    rd_mux = {{(32-ST_W){1'b0}}, status};
      REG_COUNT:     rd_mux = {{(32-PTR_W){1'b0}}, count};
      REG_IRQ_STAT:  rd_mux = {{(32-IRQ_W){1'b0}}, irq_stat_q};
      REG_IRQ_MASK:  rd_mux = {{(32-IRQ_W){1'b0}}, irq_mask_q};
      REG_EMPTY_OFF: rd_mux = {{(32-OFF_W){1'b0}}, empty_off_q};
      REG_FULL_OFF:  rd_mux = {{(32-OFF_W){1'b0}}, full_off_q};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_q <= 32'h00000000;
    end else if (ce_i) begin
      ack_q <= wb_hit;
      if (wb_hit) begin
        wb_dat_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= '0;
      irq_mask_q <= '0;
    end else if (ce_i && wb_hit && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == REG_CTRL) begin
        ctrl_q <= wb_dat_i[CTRL_W-1:0];
      end
      if (wb_adr_i == REG_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (ce_i) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = wb_dat_q;
  assign irq_o    = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_async_read;
    ce_i && !cfg_sync_rd_q && rd_edge && !in_rst && retx_n && ld_n && !empty
      |=> rptr_q == $past(rptr_q) + 20'h00001;
  endproperty
  a_async_read: assert property (p_async_read) else $error("async read skipped");
  property p_sync_read_idle;
    ce_i && cfg_sync_rd_q && !cfg_fall_q && rd_edge && ren_n && retx_n && !in_rst
      |=> $stable(rptr_q) && $stable(dout_o);
  endproperty
  a_sync_read_idle: assert property (p_sync_read_idle) else $error("read without enable");
  property p_select_hiz;
    ce_i && !in_rst && rsel_n_q |=> !dout_oe_o;
  endproperty
  a_select_hiz: assert property (p_select_hiz) else $error("driven while deselected");
  property p_reset_oe;
    ce_i && !rst_i && in_rst && !oe_n |=> dout_oe_o;
  endproperty
  a_reset_oe: assert property (p_reset_oe) else $error("reset output not driven");
  property p_retransmit;
    ce_i && retx |=> rptr_q == ($past(mark_valid_q) ? $past(mark_ptr_q) : 20'h00000)
      && empty_flag_n_o == cfg_fall_q;
  endproperty
  a_retransmit: assert property (p_retransmit) else $error("retransmit target");
  property p_retx_keeps;
    // A serial shift may share the edge and move the offsets by its own rule
    ce_i && retx && !wr_mem && !wr_off && !sc_edge
      |=> $stable(wptr_q) && $stable(empty_off_q)
      && $stable(full_off_q) && $stable(cfg_fall_q) && $stable(cfg_serial_q);
  endproperty
  a_retx_keeps: assert property (p_retx_keeps) else $error("retransmit disturbed");
  property p_serial_shift;
    ce_i && sc_edge && !sload_n && !in_mrst
      |=> full_off_q[0] == $past(si) && empty_off_q[0] == $past(full_off_q[OFF_W-1]);
  endproperty
  a_serial_shift: assert property (p_serial_shift) else $error("serial shift lost");
  property p_serial_hold;
    ce_i && !(sc_edge && !sload_n) && !wr_off && !in_mrst |=> $stable(full_off_q);
  endproperty
  a_serial_hold: assert property (p_serial_hold) else $error("offset changed idle");
  property p_sync_write_idle;
    ce_i && cfg_sync_wr_q && wr_edge && wen_n && !in_rst |=> $stable(wptr_q);
  endproperty
  a_sync_write_idle: assert property (p_sync_write_idle) else $error("write w/o enable");
  property p_async_write;
    ce_i && !cfg_sync_wr_q && wr_edge && !in_rst && !wr_gate && ld_n && !full
      |=> wptr_q == $past(wptr_q) + 20'h00001;
  endproperty
  a_async_write: assert property (p_async_write) else $error("async write lost");
  property p_write_gate;
    ce_i && wr_gate && !in_rst |=> $stable(wptr_q);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("gated write taken");
  property p_cfg_latch;
    // The last edge of system reset clears the configuration instead of latching it
    ce_i && !rst_i && in_mrst |=> cfg_sync_rd_q == $past(rtim) && cfg_sync_wr_q == $past(wtim)
      && !(cfg_fall_q && !cfg_sync_rd_q);
  endproperty
  a_cfg_latch: assert property (p_cfg_latch) else $error("config not latched");
  property p_mark;
    ce_i && rd_edge && mark && !in_rst |=> mark_valid_q && mark_ptr_q == $past(rptr_q);
  endproperty
  a_mark: assert property (p_mark) else $error("mark not recorded");
  property p_offset_write;
    ce_i && wr_off |=> $stable(wptr_q);
  endproperty
  a_offset_write: assert property (p_offset_write) else $error("offset write hit memory");

  c_retx_mark: cover property (ce_i && retx && mark_valid_q);
  c_async_wr: cover property (ce_i && wr_mem && !cfg_sync_wr_q);
  c_serial: cover property (ce_i && sc_edge && !sload_n);
  c_irq: cover property (irq_o);
  c_fall_retx: cover property (ce_i && retx && cfg_fall_q);
endmodule

// [dv/dpf_far_end.sv]
// Writer and reader pin model: strobes, serial clock and write data at a 72 ns link period
module dpf_far_end
  import dpf_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [CLK_N-1:0]  pin_clk_o,
  output logic      [DATA_W-1:0] din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin_clk_o = '0;
    din_o     = '0;
  end
  // Strobes idle low between words; the link clock never runs free
  task automatic pulse(input int k);
    @(posedge clk_i);
    pin_clk_o[k] <= 1'b1;
    repeat (4) @(posedge clk_i);
    pin_clk_o[k] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Released data shows the inverse so a stale word cannot pass for a fresh one
  task automatic wr_word(input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    din_o <= d;
    pulse(WCLK_IDX);
    din_o <= ~d;
  endtask
endmodule

// [dv/dpf_port_ctrl_bench.sv]
// Self-checking bench of the FIFO port control
module dpf_port_ctrl_bench
  import dpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       wdat = 32'h0, rdat;
  logic              ack, irq, dout_oe, ef_n, ff_n;
  logic [DATA_W-1:0] dout, din;
  logic [CLK_N-1:0]  pin;
  logic              wen_n = 1'b0, wsel_n = 1'b0, wlvl = 1'b0, wts = 1'b1;
  logic              ren_n = 1'b1, rsel_n = 1'b0, rts = 1'b1, oe_n = 1'b0;
  logic              rt_n = 1'b1, mark = 1'b0, sen_n = 1'b1, si = 1'b0;
  logic              ld_n = 1'b1, mrs_n = 1'b0, prs_n = 1'b1;
  logic [DATA_W-1:0] w [4];
  logic [31:0]       exp_q [$];
  int                n_fail = 0;
  int                checks = 0;

  always #4 clk_i = ~clk_i;

  dpf_far_end far (.clk_i(clk_i), .pin_clk_o(pin), .din_o(din));

  // Flag mode pin stays constant across every master reset
  dpf_port_ctrl dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .wr_clk_i(pin[WCLK_IDX]), .wr_en_n_i(wen_n),
    .write_select_n_i(wsel_n), .write_port_level_select_i(wlvl),
    .write_port_timing_select_i(wts), .din_i(din), .rd_clk_i(pin[RCLK_IDX]),
    .rd_en_n_i(ren_n), .read_select_n_i(rsel_n), .read_port_level_select_i(1'b0),
    .read_port_timing_select_i(rts), .out_en_n_i(oe_n), .retransmit_n_i(rt_n),
    .mark_i(mark), .ser_clk_i(pin[SCLK_IDX]), .serial_load_enable_n_i(sen_n),
    .first_word_fall_through_i(si), .offset_access_n_i(ld_n),
    .flag_timing_mode_select_i(1'b1), .master_reset_n_i(mrs_n),
    .partial_reset_n_i(prs_n), .dout_o(dout), .dout_oe_o(dout_oe),
    .empty_flag_n_o(ef_n), .full_flag_n_o(ff_n));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; a read leaves its expected word for the monitor
  task automatic wb(input logic w_, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w_;
    adr  <= a;
    wdat <= d;
    if (!w_) exp_q.push_back(d);
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (n >= 64) begin
      n_fail++;
      give_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      checks++;
      if (exp_q.size() == 0 || rdat !== exp_q[0]) begin
        n_fail++;
        $display("MISMATCH wb_dat_o expected %h seen %h", exp_q[0], rdat);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end

  task automatic mreset(input logic ts);
    @(posedge clk_i);
    wts   <= ts;
    rts   <= ts;
    mrs_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    mrs_n <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  initial begin
    void'($urandom(32'hEF7F));
    foreach (w[i]) w[i] = DATA_W'({$urandom, $urandom});
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    mreset(1'b1);
    wb(1'b0, REG_STATUS, 32'h0000002D);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      wen_n <= (i == 3);
      far.wr_word(w[i]);
    end
    wen_n <= 1'b0;
    wb(1'b0, REG_COUNT, 32'h3);
    far.pulse(RCLK_IDX);
    wb(1'b0, REG_COUNT, 32'h3);
    ren_n <= 1'b0;
    far.pulse(RCLK_IDX);
    cmp("dout_o", w[0], dout);
    $display("test sync ports done");
    si <= 1'b1;
    far.pulse(SCLK_IDX);
    wb(1'b0, REG_EMPTY_OFF, 32'h7F);
    sen_n <= 1'b0;
    far.pulse(SCLK_IDX);
    sen_n <= 1'b1;
    si    <= 1'b0;
    wb(1'b0, REG_EMPTY_OFF, 32'hFE);
    wb(1'b0, REG_FULL_OFF, 32'hFF);
    $display("test serial load done");
    mark <= 1'b1;
    far.pulse(RCLK_IDX);
    mark <= 1'b0;
    cmp("dout_o", w[1], dout);
    rt_n <= 1'b0;
    far.pulse(RCLK_IDX);
    rt_n <= 1'b1;
    cmp("empty_flag_n_o", DATA_W'(1'b0), DATA_W'(ef_n));
    wb(1'b0, REG_IRQ_STAT, 32'hC);
    wb(1'b0, REG_COUNT, 32'h2);
    wb(1'b0, REG_EMPTY_OFF, 32'hFE);
    ren_n <= 1'b1;
    far.pulse(RCLK_IDX);
    ren_n <= 1'b0;
    far.pulse(RCLK_IDX);
    cmp("dout_o", w[1], dout);
    rsel_n <= 1'b1;
    far.pulse(RCLK_IDX);
    cmp("dout_oe_o", DATA_W'(1'b0), DATA_W'(dout_oe));
    wb(1'b0, REG_COUNT, 32'h1);
    rsel_n <= 1'b0;
    far.pulse(RCLK_IDX);
    cmp("dout_o", w[2], dout);
    cmp("dout_oe_o", DATA_W'(1'b1), DATA_W'(dout_oe));
    $display("test retransmit done");
    rsel_n <= 1'b1;
    far.pulse(RCLK_IDX);
    cmp("dout_oe_o", DATA_W'(1'b0), DATA_W'(dout_oe));
    prs_n  <= 1'b0;
    repeat (6) @(posedge clk_i);
    cmp("dout_oe_o", DATA_W'(1'b1), DATA_W'(dout_oe));
    cmp("dout_o", '0, dout);
    prs_n  <= 1'b1;
    rsel_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b1, REG_IRQ_STAT, 32'hF);
    wb(1'b1, REG_IRQ_MASK, 32'h0);
    far.pulse(RCLK_IDX);
    wb(1'b0, REG_IRQ_STAT, 32'h2);
    cmp("irq_o", DATA_W'(1'b0), DATA_W'(irq));
    wb(1'b1, REG_IRQ_MASK, 32'h2);
    cmp("irq_o", DATA_W'(1'b1), DATA_W'(irq));
    wb(1'b1, REG_IRQ_STAT, 32'h2);
    cmp("irq_o", DATA_W'(1'b0), DATA_W'(irq));
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    $display("test reset and interrupt done");
    wlvl   <= 1'b1;
    wsel_n <= 1'b1;
    mreset(1'b0);
    wb(1'b0, REG_STATUS, 32'h00000121);
    far.wr_word(w[3]);
    wb(1'b0, REG_COUNT, 32'h0);
    wsel_n <= 1'b0;
    far.wr_word(w[0]);
    far.wr_word(w[1]);
    wb(1'b0, REG_COUNT, 32'h2);
    far.pulse(RCLK_IDX);
    cmp("dout_o", w[0], dout);
    far.pulse(RCLK_IDX);
    cmp("dout_o", w[1], dout);
    ld_n <= 1'b0;
    far.wr_word(36'h000000123);
    ld_n <= 1'b1;
    wb(1'b0, REG_EMPTY_OFF, 32'h123);
    $display("test async ports done");
    si    <= 1'b1;
    ren_n <= 1'b1;
    mreset(1'b1);
    si    <= 1'b0;
    wb(1'b0, REG_STATUS, 32'h0000013D);
    far.wr_word(w[2]);
    far.pulse(RCLK_IDX);
    cmp("dout_o", w[2], dout);
    cmp("empty_flag_n_o", DATA_W'(1'b0), DATA_W'(ef_n));
    rt_n <= 1'b0;
    far.pulse(RCLK_IDX);
    rt_n <= 1'b1;
    cmp("empty_flag_n_o", DATA_W'(1'b1), DATA_W'(ef_n));
    ld_n  <= 1'b0;
    ren_n <= 1'b0;
    far.pulse(RCLK_IDX);
    ld_n  <= 1'b1;
    cmp("dout_o", DATA_W'(EMPTY_OFF_RST), dout);
    $display("test fall-through done");
    give_verdict();
  end
endmodule
